// *** src/test_port_pkg.sv ***
package test_port_pkg;
   // TAP controller states, full IEEE 1149.1 set
   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
   } tap_state_e;

   // Config of one general pin: direction and drive
   typedef enum logic [1:0] {
      PIN_INPUT, PIN_OUTPUT, PIN_TRISTATE, PIN_BIDIR
   } pin_mode_e;

   // One user pin as seen from the core side
   typedef struct packed {
      pin_mode_e mode;
      logic outData;
      logic outEn;   // For tristate and bidir modes
   } user_pin_s;

   // Drive of one physical pin
   typedef struct packed {
      logic o;
      logic oe;
   } pin_drive_s;

   localparam int TLR_HOLD_CYCLES = 5;
   localparam int SYNC_STAGES = 2;
   localparam int NODE_SEL_W = 4;
   localparam int IR_W = 4;
   localparam logic [IR_W-1:0] IR_RESET = 4'h1;
   localparam logic [IR_W-1:0] IR_PROBE_SEL = 4'h2;
   localparam logic [IR_W-1:0] IR_PROBE_KILL = 4'h3;
   localparam logic [IR_W-1:0] IR_PROG = 4'h4;
endpackage

// *** src/test_port_pin_share_probe.sv ***
`timescale 1ns/1ns
module test_port_pin_share_probe
   import test_port_pkg::*;
#(
   parameter int NODES = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic modeStrap,
   input wire logic tmsIn,
   input wire logic tckIn,
   input wire logic tdiIn,
   output logic tdoOut,
   output logic tdoOe,
   output logic tckOut,
   output logic tckOe,
   output logic tdiOut,
   output logic tdiOe,
   input wire logic [NODES-1:0] nodes,
   input wire user_pin_s userTck,
   input wire user_pin_s userTdi,
   input wire user_pin_s userTdo,
   input wire user_pin_s userPra,
   input wire user_pin_s userPrb,
   output logic probe_out_a,
   output logic probe_out_aOe,
   output logic probe_out_b,
   output logic probe_out_bOe,
   output logic scanActive,
   output logic probeLocked,
   output logic progStrobe,
   output logic [IR_W-1:0] progData,
   output logic hardClkFanout
);
   // Two flop synchronisers on the link pins
   logic [SYNC_STAGES-1:0] tckS, tmsS, tdiS;
   logic tckPrev;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tckS <= '0;
         tmsS <= '1;
         tdiS <= '0;
         tckPrev <= 1'b0;
      end else begin
         tckS <= {tckS[0], tckIn};
         tmsS <= {tmsS[0], tmsIn};
         tdiS <= {tdiS[0], tdiIn};
         tckPrev <= tckS[1];
      end
   end
   logic tckRise, tckFall, tms, tdi;
   assign tckRise = tckS[1] & ~tckPrev;
   assign tckFall = ~tckS[1] & tckPrev;
   assign tms = tmsS[1];
   assign tdi = tdiS[1];

   // Strap caught after release, held until next reset
   logic dedicated, strapDone;
   logic next_dedicated, next_strapDone;
   always_comb begin
      next_dedicated = dedicated;
      next_strapDone = 1'b1;
      if (!strapDone)
         next_dedicated = modeStrap;
   end

   // TAP next state per IEEE table
   function automatic tap_state_e tapNext(tap_state_e s, logic m);
      unique case (s)
         TLR: tapNext = m ? TLR : RTI;
         RTI: tapNext = m ? SEL_DR : RTI;
         SEL_DR: tapNext = m ? SEL_IR : CAP_DR;
         CAP_DR: tapNext = m ? EX1_DR : SH_DR;
         SH_DR: tapNext = m ? EX1_DR : SH_DR;
         EX1_DR: tapNext = m ? UPD_DR : PA_DR;
         PA_DR: tapNext = m ? EX2_DR : PA_DR;
         EX2_DR: tapNext = m ? UPD_DR : SH_DR;
         UPD_DR: tapNext = m ? SEL_DR : RTI;
         SEL_IR: tapNext = m ? TLR : CAP_IR;
         CAP_IR: tapNext = m ? EX1_IR : SH_IR;
         SH_IR: tapNext = m ? EX1_IR : SH_IR;
         EX1_IR: tapNext = m ? UPD_IR : PA_IR;
         PA_IR: tapNext = m ? EX2_IR : PA_IR;
         EX2_IR: tapNext = m ? UPD_IR : SH_IR;
         UPD_IR: tapNext = m ? SEL_DR : RTI;
      endcase
   endfunction

   // TAP, claim, instruction and probe state
   tap_state_e tap, next_tap;
   logic claimed, next_claimed;
   logic [IR_W-1:0] irShift, ir, next_irShift, next_ir;
   logic [NODE_SEL_W-1:0] drShift, next_drShift;
   logic [NODE_SEL_W-1:0] selA, selB, next_selA, next_selB;
   logic probeEn, next_probeEn, next_probeLocked;
   logic next_progStrobe;
   logic [IR_W-1:0] next_progData;
   logic tdoBit, next_tdoBit;
   logic tapRun;
   always_comb begin
      next_tap = tap;
      next_claimed = claimed;
      next_irShift = irShift;
      next_ir = ir;
      next_drShift = drShift;
      next_selA = selA;
      next_selB = selB;
      next_probeEn = probeEn;
      next_probeLocked = probeLocked;
      next_progStrobe = 1'b0;
      next_progData = progData;
      next_tdoBit = tdoBit;
      // flexible mode claims on TMS low
      if (dedicated || !tms)
         next_claimed = 1'b1;
      // all scan logic advances on TCK edges
      if (tapRun && tckRise) begin
         next_tap = tapNext(tap, tms);
         unique case (tap)
            CAP_IR: next_irShift = IR_RESET;
            SH_IR: next_irShift = {tdi, irShift[IR_W-1:1]};
            CAP_DR: next_drShift = selA;
            SH_DR: next_drShift = {tdi, drShift[NODE_SEL_W-1:1]};
            default: ;
         endcase
         if (tap == UPD_IR)
            next_ir = irShift;
         if (tap == UPD_DR) begin
            unique case (ir)
               IR_PROBE_SEL: begin
                  next_selB = selA;
                  next_selA = drShift;
                  next_probeEn = 1'b1;
               end
               IR_PROBE_KILL: next_probeLocked = 1'b1;
               IR_PROG: begin
                  next_progStrobe = 1'b1;
                  next_progData = drShift;
               end
               default: ;
            endcase
         end
         // reset state ends the claim in flexible mode
         if (tapNext(tap, tms) == TLR) begin
            next_ir = IR_RESET;
            next_probeEn = 1'b0;
            if (!dedicated && tms)
               next_claimed = 1'b0;
         end
      end
      if (tapRun && tckFall)
         next_tdoBit = (tap == SH_IR) ? irShift[0] : drShift[0];
   end
   assign tapRun = claimed;

   // Pin drive: scan function or user configuration
   function automatic pin_drive_s userDrive(user_pin_s p);
      pin_drive_s d;
      d.o = p.outData;
      unique case (p.mode)
         PIN_INPUT: d.oe = 1'b0;
         PIN_OUTPUT: d.oe = 1'b1;
         PIN_TRISTATE, PIN_BIDIR: d.oe = p.outEn;
      endcase
      return d;
   endfunction

   pin_drive_s dTck, dTdi, dTdo, dPa, dPb;
   always_comb begin
      dTck = userDrive(userTck);
      dTdi = userDrive(userTdi);
      dTdo = userDrive(userTdo);
      dPa = userDrive(userPra);
      dPb = userDrive(userPrb);
      if (next_claimed) begin
         dTck = '{o: 1'b0, oe: 1'b0};
         dTdi = '{o: 1'b0, oe: 1'b0};
         dTdo = '{o: next_tdoBit,
                  oe: next_tap inside {SH_DR, SH_IR}};
      end
      if (next_probeEn && !next_probeLocked) begin
         dPa = '{o: nodes[next_selA], oe: 1'b1};
         dPb = '{o: nodes[next_selB], oe: 1'b1};
      end
   end

   // Registers; lock survives everything but power-up reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dedicated <= 1'b0;
         strapDone <= 1'b0;
         tap <= TLR;
         claimed <= 1'b0;
         irShift <= IR_RESET;
         ir <= IR_RESET;
         drShift <= '0;
         selA <= '0;
         selB <= '0;
         probeEn <= 1'b0;
         probeLocked <= 1'b0;
         progStrobe <= 1'b0;
         progData <= '0;
         tdoBit <= 1'b0;
         {tckOut, tckOe, tdiOut, tdiOe, tdoOut, tdoOe} <= '0;
         {probe_out_a, probe_out_aOe} <= '0;
         {probe_out_b, probe_out_bOe} <= '0;
         scanActive <= 1'b0;
      end else begin
         dedicated <= next_dedicated;
         strapDone <= next_strapDone;
         tap <= next_tap;
         claimed <= next_claimed;
         irShift <= next_irShift;
         ir <= next_ir;
         drShift <= next_drShift;
         selA <= next_selA;
         selB <= next_selB;
         probeEn <= next_probeEn;
         probeLocked <= next_probeLocked;
         progStrobe <= next_progStrobe;
         progData <= next_progData;
         tdoBit <= next_tdoBit;
         {tckOut, tckOe} <= dTck;
         {tdiOut, tdiOe} <= dTdi;
         {tdoOut, tdoOe} <= dTdo;
         {probe_out_a, probe_out_aOe} <= dPa;
         {probe_out_b, probe_out_bOe} <= dPb;
         scanActive <= next_claimed;
      end
   end

   // array clock tap is a register, no gating
   always_ff @(posedge clk) begin
      if (!rst_n)
         hardClkFanout <= 1'b0;
      else
         hardClkFanout <= ~hardClkFanout;
   end

   // Count consecutive TCK rises with TMS high, claimed or not
   logic [3:0] highRuns;
   always_ff @(posedge clk) begin
      if (!rst_n)
         highRuns <= '0;
      else if (tckRise && !tms)
         highRuns <= '0;
      else if (tckRise && highRuns != '1)
         highRuns <= highRuns + 4'h1;
   end

   a_five_high_reset: assert property (
      @(posedge clk) disable iff (!rst_n)
      highRuns >= 4'(TLR_HOLD_CYCLES) |-> tap == TLR)
      else $error("TAP not in reset after five TMS-high clocks");
   a_flex_release: assert property (
      @(posedge clk) disable iff (!rst_n)
      strapDone && !dedicated && tap == TLR && tms && !$rose(tms) |=>
      !scanActive) else $error("Scan pins not released in reset");
   a_tms_claim: assert property (
      @(posedge clk) disable iff (!rst_n)
      strapDone && !tms |=> scanActive)
      else $error("TMS low did not claim scan pins");
   // claim held, ends only in reset state
   a_claim_hold: assert property (
      @(posedge clk) disable iff (!rst_n)
      claimed && tap != TLR |=> claimed || tap == TLR)
      else $error("Claim dropped outside reset state");
   a_dedicated_own: assert property (
      @(posedge clk) disable iff (!rst_n)
      strapDone && dedicated |=> ##1 scanActive)
      else $error("Dedicated mode released scan pins");
   a_lock_sticky: assert property (
      @(posedge clk) disable iff (!rst_n)
      probeLocked |=> probeLocked)
      else $error("Probe lock lost");
   // locked pins show user data only
   a_lock_hides: assert property (
      @(posedge clk) disable iff (!rst_n)
      probeLocked |=> probe_out_a == $past(userPra.outData) &&
      probe_out_b == $past(userPrb.outData))
      else $error("Locked probe still shows a node");
   // probes together, same cycle as enable
   a_probe_pair: assert property (
      @(posedge clk) disable iff (!rst_n)
      probeEn && !probeLocked |-> probe_out_aOe && probe_out_bOe)
      else $error("Probes not driven together");
   a_probe_node: assert property (
      @(posedge clk) disable iff (!rst_n)
      probeEn && !probeLocked && $stable(nodes) |->
      probe_out_a == nodes[selA])
      else $error("Probe A shows wrong node");
   a_tap_on_tck: assert property (
      @(posedge clk) disable iff (!rst_n)
      !tckRise |=> $stable(tap))
      else $error("TAP moved without TCK edge");
   a_strap_fixed: assert property (
      @(posedge clk) disable iff (!rst_n)
      strapDone |=> $stable(dedicated))
      else $error("Mode changed after strap capture");
endmodule

// *** test/scan_tester.sv ***
`timescale 1ns/1ns
module scan_tester (
   input wire logic clk,
   output logic tms,
   output logic tck,
   output logic tdi
);
   initial begin
      tms = 1'b1;
      tck = 1'b0;
      tdi = 1'b0;
   end
   task automatic hold(input logic m);
      tms <= m;
   endtask
   // One TCK period of 8 clk, TDI settled well before the rise
   task automatic cyc(input logic m, input logic d);
      tms <= m;
      tdi <= d;
      tck <= 1'b0;
      repeat (4) @(posedge clk);
      tck <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   // TCK falls and stays low; released TDI must not show the old bit
   task automatic rest;
      tck <= 1'b0;
      tdi <= ~tdi;
      @(posedge clk);
   endtask
   // Four bits LSB first, TMS high on the last
   task automatic shift(input logic [3:0] v);
      for (int i = 0; i < 4; i++) begin
         cyc(i == 3, v[i]);
      end
   endtask
   task automatic ir(input logic [3:0] c);
      cyc(1'b1, 1'b0);
      cyc(1'b1, 1'b0);
      cyc(1'b0, 1'b0);
      cyc(1'b0, 1'b0);
      shift(c);
      cyc(1'b1, 1'b0);
      cyc(1'b0, 1'b0);
      rest();
   endtask
   task automatic dr(input logic [3:0] v);
      cyc(1'b1, 1'b0);
      cyc(1'b0, 1'b0);
      cyc(1'b0, 1'b0);
      shift(v);
      cyc(1'b1, 1'b0);
      cyc(1'b0, 1'b0);
      rest();
   endtask
   task automatic quit;
      repeat (5) cyc(1'b1, 1'b0);
      rest();
   endtask
endmodule

// *** test/tb_test_port_pin_share_probe.sv ***
`timescale 1ns/1ns
module tb_test_port_pin_share_probe;
   import test_port_pkg::*;
`define CMP(a, b) if ((a) !== (b)) begin bad_count++; \
   $display("BAD %0t got %h want %h", $time, a, b); end cmp_count++
   logic clk, rst_n, modeStrap, tms, tck, tdi;
   logic [15:0] nodes;
   user_pin_s userTck, userTdi, userTdo, userPra, userPrb;
   logic tdoOut, tdoOe, tckOut, tckOe, tdiOut, tdiOe, pa, paOe, pb, pbOe;
   logic scanActive, probeLocked, progStrobe, hardClkFanout;
   logic [IR_W-1:0] progData;
   int bad_count = 0, cmp_count = 0, seed = 32'h0E9C, s, t;
   typedef struct {int k; logic [3:0] v;} note_s;
   note_s q[$];
   scan_tester u_tester (.clk(clk), .tms(tms), .tck(tck), .tdi(tdi));
   test_port_pin_share_probe u_dut (.clk(clk), .rst_n(rst_n),
      .modeStrap(modeStrap), .tmsIn(tms), .tckIn(tck), .tdiIn(tdi),
      .tdoOut(tdoOut), .tdoOe(tdoOe), .tckOut(tckOut), .tckOe(tckOe),
      .tdiOut(tdiOut), .tdiOe(tdiOe), .nodes(nodes), .userTck(userTck),
      .userTdi(userTdi), .userTdo(userTdo), .userPra(userPra),
      .userPrb(userPrb), .probe_out_a(pa), .probe_out_aOe(paOe),
      .probe_out_b(pb), .probe_out_bOe(pbOe), .scanActive(scanActive),
      .probeLocked(probeLocked), .progStrobe(progStrobe),
      .progData(progData), .hardClkFanout(hardClkFanout));
   function automatic logic [3:0] act(int k);
      case (k)
         0: return {3'h0, scanActive};
         1: return {3'h0, pa};
         2: return {3'h0, pb};
         3: return {3'h0, probeLocked};
         4: return {2'h0, tdoOe, tdoOut};
         6: return {tckOe, tckOut, tdiOe, tdiOut};
         7: return {2'h0, pbOe, pb};
         default: return {2'h0, paOe, pa};
      endcase
   endfunction
   // Expected {oe, o} of a released pin from its configuration
   function automatic logic [1:0] pinExp(user_pin_s p);
      case (p.mode)
         PIN_INPUT: return {1'b0, p.outData};
         PIN_OUTPUT: return {1'b1, p.outData};
         default: return {p.outEn, p.outData};
      endcase
   endfunction
   task automatic note(int k, logic [3:0] v);
      q.push_back('{k, v});
   endtask
   task automatic end_sim;
      if (q.size() > 0)
         bad_count++;
      $display("Counts: %0d compares, %0d bad", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic rst(int n, logic m);
      rst_n <= 1'b0;
      modeStrap <= m;
      repeat (n) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   // Bounded wait so a dead claim path cannot hang the run
   task automatic claim;
      int n;
      n = 0;
      u_tester.hold(1'b0);
      while (scanActive !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      if (n == 20) begin
         bad_count++;
         end_sim();
      end else begin
         note(0, 4'h1);
         note(6, 4'h0);
      end
   endtask
   // Oldest note meets each settled result
   always @(negedge clk) begin
      if (progStrobe === 1'b1 && q.size() > 0) begin
         `CMP(progData, q[0].v);
         void'(q.pop_front());
      end
      while (q.size() > 0 && q[0].k < 8) begin
         case (q[0].k)
            0: begin `CMP(act(0), q[0].v); end
            1: begin `CMP(act(1), q[0].v); end
            2: begin `CMP(act(2), q[0].v); end
            3: begin `CMP(act(3), q[0].v); end
            4: begin `CMP(act(4), q[0].v); end
            5: begin `CMP(act(5), q[0].v); end
            6: begin `CMP(act(6), q[0].v); end
            default: begin `CMP(act(7), q[0].v); end
         endcase
         void'(q.pop_front());
      end
   end
   // Array clock tap toggles on every rising clk edge out of reset
   int fanN = 0;
   always @(negedge clk) begin
      if (rst_n !== 1'b1) begin
         fanN = 0;
      end else begin
         fanN++;
         `CMP(hardClkFanout, 1'(fanN + 1));
      end
   end
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      #500000;
      bad_count++;
      end_sim();
   end
   initial begin
      rst_n = 1'b0;
      modeStrap = 1'b0;
      @(posedge clk);
      nodes <= 16'($random(seed));
      userTck <= user_pin_s'(4'($random(seed)));
      userTdi <= user_pin_s'(4'($random(seed)));
      userPrb <= user_pin_s'(4'($random(seed)));
      userTdo <= '{PIN_OUTPUT, 1'b1, 1'b1};
      userPra <= '{PIN_OUTPUT, 1'b0, 1'b1};
      rst(12, 1'b0);
      note(4, 4'h3);
      note(6, {pinExp(userTck), pinExp(userTdi)});
      note(5, 4'h2);
      claim();
      u_tester.cyc(1'b0, 1'b0);
      $display("test claim done");
      s = {$random(seed)} % 16;
      t = (s + 5) % 16;
      u_tester.ir(IR_RESET);
      u_tester.ir(IR_PROBE_SEL);
      u_tester.dr(s[3:0]);
      note(1, {3'h0, nodes[s]});
      u_tester.dr(t[3:0]);
      note(1, {3'h0, nodes[t]});
      note(2, {3'h0, nodes[s]});
      $display("test probe done");
      u_tester.ir(IR_PROG);
      note(8, t[3:0]);
      u_tester.dr(t[3:0]);
      u_tester.ir(IR_PROBE_KILL);
      u_tester.dr(4'h0);
      note(3, 4'h1);
      note(5, 4'h2);
      note(7, {2'h0, pinExp(userPrb)});
      $display("test program and lock done");
      // From Shift-DR: four TMS-high rises keep the claim, the fifth ends it
      u_tester.cyc(1'b1, 1'b0);
      u_tester.cyc(1'b0, 1'b0);
      u_tester.cyc(1'b0, 1'b0);
      repeat (4) u_tester.cyc(1'b1, 1'b0);
      u_tester.rest();
      repeat (6) @(posedge clk);
      note(0, 4'h1);
      u_tester.cyc(1'b1, 1'b0);
      u_tester.rest();
      repeat (6) @(posedge clk);
      note(0, 4'h0);
      note(6, {pinExp(userTck), pinExp(userTdi)});
      note(3, 4'h1);
      note(4, 4'h3);
      $display("test release done");
      rst(3, 1'b1);
      modeStrap <= 1'b0;
      u_tester.quit();
      repeat (6) @(posedge clk);
      note(0, 4'h1);
      $display("test dedicated done");
      repeat (4) @(posedge clk);
      end_sim();
   end
endmodule
